// ===== shared/synth_load_map.svh
`ifndef SYNTH_LOAD_MAP_SVH
`define SYNTH_LOAD_MAP_SVH
`define WORD_BITS 24
`define BYTE_BITS 8
`define BYTES_PER_WORD 3
`define SEL_LO_BIT 0
`define SEL_HI_BIT 1
`define SEL_FIRST_REF 2'h0
`define SEL_FIRST_DIV 2'h1
`define SEL_SECOND_REF 2'h2
`define SEL_SECOND_DIV 2'h3
`define ALL_LATCHES_SEEN 4'hF
`define LINK_MAX_HZ 20000000
`define REF_CLK_HZ 20000000
`define CLK_DIV_HALF 2
`define STROBE_HOLD_CYCLES 2
`endif

// ===== shared/synth_load_pkg.sv
package synth_load_pkg;
  `include "synth_load_map.svh"
  typedef logic [`WORD_BITS-1:0] word_type;
  typedef logic [1:0] latch_sel_type;
  typedef enum logic [2:0] {
    host_idle,
    host_arm,
    host_low,
    host_high,
    host_strobe
  } host_state_type;
endpackage : synth_load_pkg

// ===== shared/serial_load_if.sv
`timescale 1ns/100ps
interface serial_load_if;
  logic host_serial_clock; // link clock, made by the host
  logic serial_data; // data, msb first
  logic word_load_strobe; // commit on rising edge
  modport host (output host_serial_clock, output serial_data, output word_load_strobe);
  modport device (input host_serial_clock, input serial_data, input word_load_strobe);
endinterface : serial_load_if

// ===== logic/serial_load_host.sv
`timescale 1ns/100ps
module serial_load_host
  import synth_load_pkg::*;
(
  input wire logic ref_clk_i, // 20 MHz system clock
  input wire logic sys_rst_i, // synchronous, active high
  input wire logic send_i, // one-cycle request
  input wire word_type word_i, // word to send, taken with send_i
  output logic busy_o, // high while a word is in flight
  output logic done_o, // one-cycle pulse after strobe
  serial_load_if.host link // serial pins
);
  localparam int HALF = `CLK_DIV_HALF; // 20 MHz / 4 = 5 MHz link
  localparam int LAST_BIT = `BYTE_BITS - 1; // index of a byte's last bit
  localparam int LAST_BYTE = `BYTES_PER_WORD - 1; // index of a word's last byte
  localparam int LAST_HOLD = `STROBE_HOLD_CYCLES; // strobe ticks before release

  // divider state
  logic [1:0] div_cnt;
  logic [1:0] next_div_cnt;
  logic tick;

  // sequencer state
  host_state_type state;
  host_state_type next_state;
  logic [2:0] bit_idx;
  logic [2:0] next_bit_idx;
  logic [1:0] byte_idx;
  logic [1:0] next_byte_idx;
  logic [1:0] hold_cnt;
  logic [1:0] next_hold_cnt;

  // data path state
  word_type word_q;
  word_type next_word_q;
  logic [`BYTE_BITS-1:0] byte_q;
  logic [`BYTE_BITS-1:0] next_byte_q;
  logic sdata;
  logic next_sdata;

  // pin and status state
  logic sclk;
  logic next_sclk;
  logic strobe;
  logic next_strobe;
  logic busy;
  logic next_busy;
  logic done;
  logic next_done;

  // sequencer events, decoded once and shared by the groups below
  logic take_word; // request accepted
  logic load_byte; // first bit of the next byte onto the data pin
  logic shift_bit; // next bit of the current byte onto the data pin
  logic rise_clk; // link clock goes high
  logic fall_clk; // link clock goes low
  logic raise_stb; // load strobe goes or stays high
  logic finish; // strobe released, frame over

  // divider: the link clock moves only on a tick, so its rate is fixed
  // by HALF and cannot creep above the 20 MHz limit
  always_comb begin
    next_div_cnt = tick ? 2'h0 : div_cnt + 2'h1;
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      div_cnt <= 2'h0;
    end else begin
      div_cnt <= next_div_cnt;
    end
  end

  assign tick = (div_cnt == 2'(HALF - 1));

  // frame sequencer: arm, 24 low/high bit cells, then the strobe
  always_comb begin
    next_state = state;
    next_bit_idx = bit_idx;
    next_byte_idx = byte_idx;
    next_hold_cnt = hold_cnt;
    take_word = 1'b0;
    load_byte = 1'b0;
    shift_bit = 1'b0;
    rise_clk = 1'b0;
    fall_clk = 1'b0;
    raise_stb = 1'b0;
    finish = 1'b0;
    unique case (state)
      host_idle: begin
        // only looked at when idle, so requests while busy are dropped
        if (send_i) begin
          take_word = 1'b1;
          next_byte_idx = 2'h0;
          next_state = host_arm;
        end
      end
      host_arm: begin
        if (tick) begin
          load_byte = 1'b1; // first byte, msb first
          next_bit_idx = 3'h0;
          next_state = host_low;
        end
      end
      host_low: begin
        if (tick) begin
          rise_clk = 1'b1; // data has stood a half period
          next_state = host_high;
        end
      end
      host_high: begin
        if (tick) begin
          fall_clk = 1'b1; // data moves only with the falling edge
          next_state = host_low;
          if (bit_idx != 3'(LAST_BIT)) begin
            shift_bit = 1'b1;
            next_bit_idx = bit_idx + 3'h1;
          end else if (byte_idx != 2'(LAST_BYTE)) begin
            // next byte follows with no gap and no strobe
            load_byte = 1'b1;
            next_bit_idx = 3'h0;
            next_byte_idx = byte_idx + 2'h1;
          end else begin
            // third byte done: the 24-bit word is complete
            next_hold_cnt = 2'h0;
            next_state = host_strobe;
          end
        end
      end
      host_strobe: begin
        // strobe stands two half periods, long enough for the far synchroniser
        if (tick) begin
          if (hold_cnt == 2'(LAST_HOLD)) begin
            finish = 1'b1;
            next_state = host_idle;
          end else begin
            raise_stb = 1'b1; // commit only after the last byte
            next_hold_cnt = hold_cnt + 2'h1;
          end
        end
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      state <= host_idle;
      bit_idx <= 3'h0;
      byte_idx <= 2'h0;
      hold_cnt <= 2'h0;
    end else begin
      state <= next_state;
      bit_idx <= next_bit_idx;
      byte_idx <= next_byte_idx;
      hold_cnt <= next_hold_cnt;
    end
  end

  // data path: a byte-wide shifter fed from the word, msb first
  always_comb begin
    next_word_q = word_q;
    next_byte_q = byte_q;
    next_sdata = sdata;
    if (take_word) begin
      next_word_q = word_i;
    end else if (load_byte) begin
      next_sdata = word_q[`WORD_BITS-1];
      next_byte_q = {word_q[`WORD_BITS-2 -: `BYTE_BITS-1], 1'b0};
      next_word_q = {word_q[`WORD_BITS-`BYTE_BITS-1:0], {`BYTE_BITS{1'b0}}};
    end else if (shift_bit) begin
      next_sdata = byte_q[`BYTE_BITS-1];
      next_byte_q = {byte_q[`BYTE_BITS-2:0], 1'b0};
    end
  end

  // data path registers
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      word_q <= '0;
      byte_q <= '0;
      sdata <= 1'b0;
    end else begin
      word_q <= next_word_q;
      byte_q <= next_byte_q;
      sdata <= next_sdata;
    end
  end

  // pins and status; the strobe is forced low on acceptance, before any bit
  always_comb begin
    next_sclk = sclk;
    next_strobe = strobe;
    next_busy = busy;
    next_done = 1'b0;
    if (take_word) begin
      next_busy = 1'b1;
      next_strobe = 1'b0; // strobe low before shifting
    end
    if (rise_clk) begin
      next_sclk = 1'b1;
    end
    if (fall_clk) begin
      next_sclk = 1'b0;
    end
    if (raise_stb) begin
      next_strobe = 1'b1;
    end
    if (finish) begin
      next_strobe = 1'b0;
      next_busy = 1'b0;
      next_done = 1'b1;
    end
  end

  // pin and status registers
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      sclk <= 1'b0;
      strobe <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      sclk <= next_sclk;
      strobe <= next_strobe;
      busy <= next_busy;
      done <= next_done;
    end
  end

  assign link.host_serial_clock = sclk;
  assign link.serial_data = sdata;
  assign link.word_load_strobe = strobe;
  assign busy_o = busy;
  assign done_o = done;
endmodule : serial_load_host

// ===== logic/serial_load_device.sv
`timescale 1ns/100ps
module serial_load_device
  import synth_load_pkg::*;
(
  input wire logic ref_clk_i, // 20 MHz user clock
  input wire logic sys_rst_i, // synchronous, active high
  serial_load_if.device link, // serial pins
  output word_type first_ref_o, // section one reference latch
  output word_type first_div_o, // section one divider latch
  output word_type second_ref_o, // section two reference latch
  output word_type second_div_o, // section two divider latch
  output logic output_active_o, // high once all four latches written
  output logic commit_o // one-cycle pulse per committed word
);
  // link domain: shifter only, runs on host clock
  word_type shreg;
  word_type next_shreg;
  always_comb begin
    next_shreg = {shreg[`WORD_BITS-2:0], link.serial_data}; // msb first
  end
  always_ff @(posedge link.host_serial_clock) begin
    shreg <= next_shreg;
  end

  // strobe synchronised into ref clock; shreg is still while strobe high
  logic stb_meta;
  logic stb_sync;
  logic stb_prev;
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      stb_meta <= 1'b0;
      stb_sync <= 1'b0;
      stb_prev <= 1'b0;
    end else begin
      stb_meta <= link.word_load_strobe;
      stb_sync <= stb_meta;
      stb_prev <= stb_sync;
    end
  end

  word_type latch_q [4];
  word_type next_latch [4];
  logic [3:0] seen;
  logic [3:0] next_seen;
  logic active;
  logic next_active;
  logic commit;
  logic next_commit;
  latch_sel_type sel;

  // select bits: two last-shifted bits
  assign sel = {shreg[`SEL_HI_BIT], shreg[`SEL_LO_BIT]};

  // latch update on strobe rise, no power-down gating
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      next_latch[i] = latch_q[i];
    end
    next_seen = seen;
    next_commit = 1'b0;
    if (stb_sync && !stb_prev) begin
      next_latch[sel] = shreg;
      next_seen[sel] = 1'b1;
      next_commit = 1'b1;
    end
    next_active = (next_seen == `ALL_LATCHES_SEEN);
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < 4; i++) begin
        latch_q[i] <= '0;
      end
      seen <= 4'h0;
      active <= 1'b0;
      commit <= 1'b0;
    end else begin
      latch_q <= next_latch;
      seen <= next_seen;
      active <= next_active;
      commit <= next_commit;
    end
  end

  assign first_ref_o = latch_q[`SEL_FIRST_REF];
  assign first_div_o = latch_q[`SEL_FIRST_DIV];
  assign second_ref_o = latch_q[`SEL_SECOND_REF];
  assign second_div_o = latch_q[`SEL_SECOND_DIV];
  assign output_active_o = active;
  assign commit_o = commit;
endmodule : serial_load_device

// ===== dv/serial_load_sva.sv
`timescale 1ns/100ps
module serial_load_sva (
  input wire logic ref_clk_i, // user clock
  input wire logic sys_rst_i, // sync reset
  input wire logic host_serial_clock, // link clock
  input wire logic serial_data, // link data
  input wire logic word_load_strobe // commit strobe
);
  logic [4:0] rises; // link rises since last strobe
  logic last_clk; // link clock one cycle ago
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  // strobe restarts the count, so a stray rise shows in the next frame
  always_ff @(posedge ref_clk_i) begin
    last_clk <= host_serial_clock;
    if (sys_rst_i || word_load_strobe) rises <= 5'h00;
    else if (host_serial_clock && !last_clk) rises <= rises + 5'h01;
  end
  a_clk_high_two: assert property ($rose(host_serial_clock) |=> host_serial_clock ##1 !host_serial_clock)
    else $error("link clock high time wrong");
  a_clk_low_two: assert property ($fell(host_serial_clock) |=> !host_serial_clock)
    else $error("link clock low time too short");
  a_data_settled: assert property ($rose(host_serial_clock) |-> $stable(serial_data) ##1 $stable(serial_data))
    else $error("data moved around rising link clock");
  a_frame_length: assert property ($rose(word_load_strobe) |-> rises == 5'h18)
    else $error("frame length not 24 rises");
  a_no_extra_bit: assert property ($rose(host_serial_clock) |-> rises < 5'h18)
    else $error("rise beyond frame length");
  a_strobe_low_shift: assert property ($rose(host_serial_clock) |-> !word_load_strobe)
    else $error("shifting while strobe high");
  a_clock_still_strobe: assert property (word_load_strobe |-> $stable(host_serial_clock))
    else $error("link clock moved while strobe high");
  a_strobe_hold: assert property ($rose(word_load_strobe) |-> word_load_strobe[*3])
    else $error("strobe pulse too short");
endmodule : serial_load_sva

// ===== dv/synth_serial_load_port_test.sv
`timescale 1ns/100ps
module synth_serial_load_port_test;
  import synth_load_pkg::*;
  logic ref_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic send_i = 1'b0;
  word_type word_i = 24'h000000;
  logic busy_o, done_o, output_active_o, commit_o;
  word_type lat [4];
  word_type exp_lat [4] = '{default: 24'h000000};
  word_type wl [6] = '{24'hA5C3F0, 24'h5A3C0D, 24'h800002, 24'hFFFFFF, 24'h000001, 24'h7FFFFE};
  int fail_count = 0;
  int n_compared = 0;
  int commits = 0;
  serial_load_if link ();
  serial_load_host serial_load_host_i (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .send_i(send_i), .word_i(word_i), .busy_o(busy_o), .done_o(done_o), .link(link));
  serial_load_device serial_load_device_i (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .link(link), .first_ref_o(lat[0]), .first_div_o(lat[1]), .second_ref_o(lat[2]),
    .second_div_o(lat[3]), .output_active_o(output_active_o), .commit_o(commit_o));
  serial_load_sva serial_load_sva_i (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .host_serial_clock(link.host_serial_clock), .serial_data(link.serial_data),
    .word_load_strobe(link.word_load_strobe));
  // clock and commit pulse counting
  initial forever #25 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) if (commit_o === 1'b1) commits++;
  task check(string n, word_type e, word_type s);
    n_compared++;
    if (s !== e) begin
      $display("mismatch %s expected %h seen %h", n, e, s);
      fail_count++;
    end
  endtask : check
  task test_done;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  // one word; poke sends a stray request mid-flight that must be ignored
  task send(word_type w, bit poke);
    int i;
    @(posedge ref_clk_i);
    #5 send_i = 1'b1;
    word_i = w;
    @(posedge ref_clk_i);
    #5 send_i = 1'b0;
    check("busy", 24'h000001, {23'h000000, busy_o});
    if (poke) begin
      repeat (3) @(posedge ref_clk_i);
      #5 send_i = 1'b1;
      word_i = 24'h123457;
      @(posedge ref_clk_i);
      #5 send_i = 1'b0;
    end
    for (i = 0; i < 400 && done_o !== 1'b1; i++) begin
      @(posedge ref_clk_i);
      #5;
    end
    if (i == 400) begin
      fail_count++;
      test_done();
    end
  endtask : send
  // main sequence: three latches, the fourth, then overwrites
  initial begin
    repeat (2) @(posedge ref_clk_i);
    #5 sys_rst_i = 1'b0;
    check("active", 24'h000000, {23'h000000, output_active_o});
    for (int k = 0; k < 6; k++) begin
      send(wl[k], k == 4);
      exp_lat[wl[k][1:0]] = wl[k];
      for (int j = 0; j < 4; j++) check("latch", exp_lat[j], lat[j]);
      check("active", {23'h000000, k >= 3}, {23'h000000, output_active_o});
      check("commits", word_type'(k + 1), word_type'(commits));
      check("idle", 24'h000000, {23'h000000, busy_o});
      $display("test %0d done", k);
    end
    test_done();
  end
endmodule : synth_serial_load_port_test
